// [dsc_consts.svh]
// Constants of the DAC serial command port: frame sizes, timing, encodings.
// Included by the package and by every module that needs a figure.
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

// ------------------------------------------------------------
// Frame layout
// ------------------------------------------------------------
`define DSC_WORD_W 32
`define DSC_LEN_SHORT 6'h18
`define DSC_LEN_LONG 6'h20
`define DSC_CNT_MAX 6'h3F
`define DSC_CRC_W 6
`define DSC_CRC_POLY 6'h03
`define DSC_CRC_INIT 6'h00
`define DSC_NUM_CH 8

// ------------------------------------------------------------
// Command encodings
// ------------------------------------------------------------
`define DSC_OP_WR_CODE 4'h0
`define DSC_OP_WR_SPAN 4'h1
`define DSC_OP_WR_CODE_UPD 4'h4
`define DSC_OP_WR_CODE_UPD_ALL 4'h5
`define DSC_OP_RD_CODE 4'h8
`define DSC_OP_RD_SPAN 4'h9
`define DSC_CMD_WR_CONFIG 8'h70
`define DSC_CMD_WR_FAULT 8'h76
`define DSC_CMD_RD_CONFIG 8'hF0
`define DSC_CMD_RD_FAULT 8'hF6
`define DSC_CMD_SOFT_RESET 8'h7F

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define DSC_SPAN_RST 4'h0
`define DSC_CODE_RST 16'h0000

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define DSC_CLK_NS 100
`define DSC_SCK_PERIOD_NS 1600
`define DSC_SCK_HALF_CYC (((`DSC_SCK_PERIOD_NS) / 2) / (`DSC_CLK_NS))

`endif

// [dsc_pkg.sv]
// Types shared by both ends of the DAC serial command port.
// Assumes dsc_consts.svh is on the include path.
`default_nettype none
`include "dsc_consts.svh"

package dsc_pkg;

   // ------------------------------------------------------------
   // Device end state
   // ------------------------------------------------------------
   typedef struct packed {
      logic sck_prev;
      logic fsl_prev;
      logic [31:0] shift;
      logic [5:0] nbits;
      logic [31:0] echo;
      logic sdo;
      logic cmd_valid;
      logic [7:0] cmd_byte;
      logic [15:0] cmd_data;
      logic fault_len;
      logic fault_crc;
      logic [7:0][15:0] code;
      logic [7:0][3:0] span;
   } dsc_dev_state_t;

   // ------------------------------------------------------------
   // Host end state
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      DSC_H_IDLE,
      DSC_H_LEAD,
      DSC_H_LOW,
      DSC_H_HIGH,
      DSC_H_TRAIL,
      DSC_H_GAP
   } dsc_host_mode_t;

   typedef struct packed {
      dsc_host_mode_t mode;
      logic [7:0] timer;
      logic [5:0] bit_idx;
      logic [5:0] nbits;
      logic fsl;
      logic sck;
      logic sdi;
      logic [31:0] shift;
      logic [31:0] rx_shift;
      logic [31:0] rx_word;
      logic done;
   } dsc_host_state_t;

endpackage

`default_nettype wire

// [dsc_link_if.sv]
// Serial link between host master and DAC command port.
// Assumes the bench supplies no driver of its own; sdo idles high when released.
`timescale 1ns/1ns
`default_nettype none

interface dsc_link_if;
   logic frame_select_load;
   logic sck;
   logic sdi;
   logic sdo_out;
   logic sdo_oe;
   logic sdo;

   // Released line reads as pulled high
   assign sdo = sdo_oe ? sdo_out : 1'b1;

   modport device (input frame_select_load, input sck, input sdi, output sdo_out, output sdo_oe);
   modport host (output frame_select_load, output sck, output sdi, input sdo);
endinterface

`default_nettype wire

// [dsc_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none

module dsc_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] level;
   } dsc_sync_state_t;

   dsc_sync_state_t st;
   dsc_sync_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < W; i++) begin
         // Change counts once stages two and three agree
         if (st.s2[i] == st.s3[i]) begin
            next_st.level[i] = st.s3[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         // Idle pin levels, so no false edge after reset
         st.s1 <= INIT;
         st.s2 <= INIT;
         st.s3 <= INIT;
         st.level <= INIT;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.level;
endmodule

`default_nettype wire

// [dsc_device.sv]
// Device end of the DAC serial command port: shift, check and execute frames.
// Assumes frame_select_load, sck and sdi come from another clock domain.
//
// Summary of operation
// - Capture data on sck rise, select low
// - Ignore sck and data while deselected
// - Select rise ends frame, executes command
// - Accept 24-bit and 32-bit frames
// - Command byte, two data bytes, CRC
// - CRC checked only on 32-bit frames
// - Chained frames of 64 bits flag fault_len
// - Reset returns all registers to defaults
// - Reset span 0-5 V, code zero
// - Host issues software reset after power-up
// - Data out on falling edge, released deselected
// - Write words echoed in next frame
// - Low nibble of command is channel
// - Count edges, fault on bad length
`timescale 1ns/1ns
`default_nettype none
`include "dsc_consts.svh"

module dsc_device (
   input wire logic clk,
   input wire logic rst,
   dsc_link_if.device link,
   input wire logic crc_enable,
   output logic cmd_valid,
   output logic [7:0] cmd_byte,
   output logic [15:0] cmd_data,
   output logic fault_len,
   output logic fault_crc,
   output logic [7:0][15:0] chan_code,
   output logic [7:0][3:0] chan_span
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [5:0] crc6(input logic [23:0] msg);
      logic [5:0] c;
      logic fb;
      c = `DSC_CRC_INIT;
      for (int i = 23; i >= 0; i--) begin
         fb = c[5] ^ msg[i];
         c = {c[4:0], 1'b0};
         if (fb) begin
            c = c ^ `DSC_CRC_POLY;
         end
      end
      return c;
   endfunction

   function automatic logic crc_exempt(input logic [7:0] cb);
      return (cb == `DSC_CMD_WR_CONFIG) || (cb == `DSC_CMD_RD_CONFIG) ||
             (cb == `DSC_CMD_WR_FAULT) || (cb == `DSC_CMD_RD_FAULT);
   endfunction

   function automatic logic chan_ok(input logic [7:0] cb);
      return cb[3:0] < 4'(`DSC_NUM_CH);
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] pins;
   logic fsl_s;
   logic sck_s;
   logic sdi_s;

   dsc_pin_sync #(.W(3), .INIT(3'h4)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({link.frame_select_load, link.sck, link.sdi}),
      .q(pins)
   );

   assign fsl_s = pins[2];
   assign sck_s = pins[1];
   assign sdi_s = pins[0];

   // ------------------------------------------------------------
   // Frame engine
   // ------------------------------------------------------------
   dsc_pkg::dsc_dev_state_t st;
   dsc_pkg::dsc_dev_state_t next_st;

   logic sck_rise;
   logic sck_fall;
   logic len_short;
   logic len_long;
   logic [31:0] word;
   logic [7:0] cb;
   logic [15:0] rd_data;
   logic crc_bad;

   always_comb begin
      next_st = st;
      next_st.cmd_valid = 1'b0;
      next_st.sck_prev = sck_s;
      next_st.fsl_prev = fsl_s;
      sck_rise = sck_s && !st.sck_prev;
      sck_fall = !sck_s && st.sck_prev;
      len_short = st.nbits == `DSC_LEN_SHORT;
      len_long = st.nbits == `DSC_LEN_LONG;
      word = len_long ? st.shift : {st.shift[23:0], 8'h00};
      cb = word[31:24];
      crc_bad = len_long && crc_enable && !crc_exempt(cb) && (crc6(word[31:8]) != word[5:0]);
      rd_data = 16'h0000;
      if (chan_ok(cb)) begin
         case (cb[7:4])
            `DSC_OP_RD_CODE: rd_data = st.code[cb[2:0]];
            `DSC_OP_RD_SPAN: rd_data = {12'h000, st.span[cb[2:0]]};
            default: rd_data = 16'h0000;
         endcase
      end

      if (!fsl_s) begin
         if (st.fsl_prev) begin
            // Frame start: count afresh, present first echo bit
            next_st.nbits = 6'h00;
            next_st.sdo = st.echo[31];
         end else begin
            if (sck_rise) begin
               next_st.shift = {st.shift[30:0], sdi_s};
               if (st.nbits != `DSC_CNT_MAX) begin
                  next_st.nbits = st.nbits + 6'h01;
               end
            end
            if (sck_fall) begin
               next_st.sdo = st.echo[30];
               next_st.echo = {st.echo[30:0], 1'b0};
            end
         end
      end else if (!st.fsl_prev) begin
         next_st.echo = 32'h0000_0000;
         if (!(len_short || len_long)) begin
            next_st.fault_len = 1'b1;
         end else if (crc_bad) begin
            next_st.fault_crc = 1'b1;
            next_st.fault_len = 1'b0;
         end else begin
            next_st.fault_len = 1'b0;
            next_st.fault_crc = 1'b0;
            next_st.cmd_valid = 1'b1;
            next_st.cmd_byte = cb;
            next_st.cmd_data = word[23:8];
            if (!cb[7]) begin
               next_st.echo = word;
            end else if (len_long) begin
               next_st.echo = {cb, rd_data, 8'h00};
            end else begin
               next_st.echo = {8'h00, rd_data, 8'h00};
            end
            if (chan_ok(cb)) begin
               case (cb[7:4])
                  `DSC_OP_WR_CODE, `DSC_OP_WR_CODE_UPD, `DSC_OP_WR_CODE_UPD_ALL: begin
                     next_st.code[cb[2:0]] = word[23:8];
                  end
                  `DSC_OP_WR_SPAN: begin
                     next_st.span[cb[2:0]] = word[11:8];
                  end
                  default: begin
                  end
               endcase
            end
            if (cb == `DSC_CMD_SOFT_RESET) begin
               next_st.code = {`DSC_NUM_CH{`DSC_CODE_RST}};
               next_st.span = {`DSC_NUM_CH{`DSC_SPAN_RST}};
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
         st.fsl_prev <= 1'b1;
         st.sdo <= 1'b1;
         st.code <= {`DSC_NUM_CH{`DSC_CODE_RST}};
         st.span <= {`DSC_NUM_CH{`DSC_SPAN_RST}};
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign link.sdo_out = st.sdo;
   assign link.sdo_oe = !fsl_s && !st.fsl_prev;
   assign cmd_valid = st.cmd_valid;
   assign cmd_byte = st.cmd_byte;
   assign cmd_data = st.cmd_data;
   assign fault_len = st.fault_len;
   assign fault_crc = st.fault_crc;
   assign chan_code = st.code;
   assign chan_span = st.span;
endmodule

`default_nettype wire

// [dsc_host.sv]
// Host end of the DAC serial command port: sends one 24- or 32-bit frame per start.
// Assumes the device answers on sdo; sck is made here from clk.
`timescale 1ns/1ns
`default_nettype none
`include "dsc_consts.svh"

module dsc_host (
   input wire logic clk,
   input wire logic rst,
   dsc_link_if.host link,
   input wire logic start,
   input wire logic [31:0] tx_word,
   input wire logic tx_long,
   output logic busy,
   output logic done,
   output logic [31:0] rx_word
);
   localparam logic [7:0] HALF_LAST = 8'(`DSC_SCK_HALF_CYC - 1);
   localparam logic [7:0] GAP_LAST = 8'(2 * `DSC_SCK_HALF_CYC - 1);

   logic sdo_s;

   dsc_pin_sync #(.W(1), .INIT(1'h1)) u_sync (
      .clk(clk),
      .rst(rst),
      .d(link.sdo),
      .q(sdo_s)
   );

   // ------------------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------------------
   dsc_pkg::dsc_host_state_t st;
   dsc_pkg::dsc_host_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      next_st.timer = st.timer + 8'h01;
      case (st.mode)
         dsc_pkg::DSC_H_IDLE: begin
            next_st.timer = 8'h00;
            if (start) begin
               // frame of 24 or 32 bits
               next_st.shift = tx_word;
               next_st.nbits = tx_long ? `DSC_LEN_LONG : `DSC_LEN_SHORT;
               next_st.bit_idx = 6'h00;
               next_st.rx_shift = 32'h0000_0000;
               next_st.fsl = 1'b0;
               next_st.mode = dsc_pkg::DSC_H_LEAD;
            end
         end
         dsc_pkg::DSC_H_LEAD: begin
            if (st.timer == HALF_LAST) begin
               next_st.timer = 8'h00;
               next_st.sdi = st.shift[31];
               next_st.shift = {st.shift[30:0], 1'b0};
               next_st.mode = dsc_pkg::DSC_H_LOW;
            end
         end
         dsc_pkg::DSC_H_LOW: begin
            if (st.timer == HALF_LAST) begin
               next_st.timer = 8'h00;
               next_st.sck = 1'b1;
               next_st.mode = dsc_pkg::DSC_H_HIGH;
            end
         end
         dsc_pkg::DSC_H_HIGH: begin
            if (st.timer == HALF_LAST) begin
               next_st.timer = 8'h00;
               next_st.sck = 1'b0;
               next_st.rx_shift = {st.rx_shift[30:0], sdo_s};
               next_st.bit_idx = st.bit_idx + 6'h01;
               if (st.bit_idx == st.nbits - 6'h01) begin
                  next_st.mode = dsc_pkg::DSC_H_TRAIL;
               end else begin
                  next_st.sdi = st.shift[31];
                  next_st.shift = {st.shift[30:0], 1'b0};
                  next_st.mode = dsc_pkg::DSC_H_LOW;
               end
            end
         end
         dsc_pkg::DSC_H_TRAIL: begin
            if (st.timer == HALF_LAST) begin
               next_st.timer = 8'h00;
               next_st.fsl = 1'b1;
               next_st.mode = dsc_pkg::DSC_H_GAP;
            end
         end
         dsc_pkg::DSC_H_GAP: begin
            if (st.timer == GAP_LAST) begin
               next_st.timer = 8'h00;
               next_st.rx_word = st.rx_shift;
               next_st.done = 1'b1;
               next_st.mode = dsc_pkg::DSC_H_IDLE;
            end
         end
         default: begin
            next_st.mode = dsc_pkg::DSC_H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
         st.mode <= dsc_pkg::DSC_H_IDLE;
         st.fsl <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign link.frame_select_load = st.fsl;
   assign link.sck = st.sck;
   assign link.sdi = st.sdi;
   assign busy = st.mode != dsc_pkg::DSC_H_IDLE;
   assign done = st.done;
   assign rx_word = st.rx_word;
endmodule

`default_nettype wire

// [dsc_link_sva.sv]
// Checker of the serial link between the host and device ends.
// Assumes the link's signals and the host's clock and reset as inputs.
`timescale 1ns/1ns
`default_nettype none

module dsc_link_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic frame_select_load,
   input wire logic sck,
   input wire logic sdi,
   input wire logic sdo_out,
   input wire logic sdo_oe,
   input wire logic sdo
);
   logic sck_q;
   logic rise;
   logic last_ok;
   logic last_msb;
   logic [5:0] cnt;
   logic [31:0] cap;

   // ----------
   // Frame tracking
   // ----------
   assign rise = sck & ~sck_q;

   always_ff @(posedge clk) begin
      sck_q <= sck;
      if (rst) begin
         cnt <= 6'h00;
         last_ok <= 1'h0;
      end else if (!frame_select_load && rise) begin
         cnt <= cnt + 6'h01;
         cap <= {cap[30:0], sdi};
      end else if (frame_select_load && cnt != 6'h00) begin
         cnt <= 6'h00;
         last_ok <= cnt == 6'h18 || cnt == 6'h20;
         last_msb <= cnt == 6'h20 && cap[31];
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence lead_quiet;
      !sck [*8];
   endsequence

   sequence bit_hold;
      $stable(sdi) [*7];
   endsequence

   // ----------
   // Link rules
   // ----------
   oe_release_a: assert property (frame_select_load [*8] |-> !sdo_oe)
      else $error("sdo driven while deselected");
   oe_drive_a: assert property ($fell(frame_select_load) |-> ##[1:8] sdo_oe)
      else $error("sdo not driven in frame");
   sdo_hold_a: assert property (sck [*8] |-> $stable(sdo_out))
      else $error("sdo moved while sck high");
   echo_msb_a: assert property (rise && cnt == 6'h00 && !frame_select_load && last_ok |-> sdo == last_msb)
      else $error("first echoed bit wrong");
   sck_gate_a: assert property ($changed(sck) |-> !frame_select_load)
      else $error("sck moved while deselected");
   sck_idle_a: assert property (frame_select_load |-> !sck)
      else $error("sck high while deselected");
   sdi_hold_a: assert property ($rose(sck) |=> bit_hold)
      else $error("sdi moved while sck high");
   len_ok_a: assert property ($rose(frame_select_load) |-> cnt == 6'h18 || cnt == 6'h20)
      else $error("frame length not 24 or 32");
   sel_gap_a: assert property ($rose(frame_select_load) |=> frame_select_load [*5])
      else $error("select gap too short");
   lead_gap_a: assert property ($fell(frame_select_load) |-> lead_quiet)
      else $error("sck too soon after select");
endmodule

`default_nettype wire

// [tb_dac_serial_command_port.sv]
// Self-checking bench: host and device ends joined over the serial link.
// Assumes the design files and dsc_consts.svh are compiled before it.
`timescale 1ns/1ns
`default_nettype none

module tb_dac_serial_command_port;
   typedef struct packed {
      logic [31:0] word;
      logic long_f;
      logic [31:0] rx;
      logic chk_rx;
      logic [2:0] ch;
      logic [15:0] code;
      logic [3:0] span;
   } dsc_row_t;

   logic clk;
   logic rst;
   logic start;
   logic [31:0] tx_word;
   logic tx_long;
   logic busy;
   logic done;
   logic [31:0] rx_word;
   logic cmd_valid;
   logic [7:0] cmd_byte;
   logic [15:0] cmd_data;
   logic fault_len;
   logic fault_crc;
   logic [7:0][15:0] chan_code;
   logic [7:0][3:0] chan_span;
   logic b_valid;
   logic b_flen;
   logic b_fcrc;
   logic [7:0][15:0] b_code;
   int n_errors = 0, num_checks = 0, n_valid = 0, b_n = 0, cycles = 0;
   int nv;
   int i;
   dsc_row_t rows [0:11] = '{
      '{32'h7F000000, 1'h1, 32'h00000000, 1'h1, 3'h0, 16'h0000, 4'h0}, // software reset first
      '{32'h03A5C300, 1'h0, 32'h007F0000, 1'h1, 3'h3, 16'hA5C3, 4'h0},
      '{32'h17000500, 1'h1, 32'h03A5C300, 1'h1, 3'h7, 16'h0000, 4'h5},
      '{32'h40123400, 1'h1, 32'h17000500, 1'h1, 3'h0, 16'h1234, 4'h0},
      '{32'h51BEEF00, 1'h1, 32'h40123400, 1'h1, 3'h1, 16'hBEEF, 4'h0},
      '{32'h09FFFF00, 1'h1, 32'h51BEEF00, 1'h1, 3'h1, 16'hBEEF, 4'h0},
      '{32'h83000000, 1'h1, 32'h09FFFF00, 1'h1, 3'h3, 16'hA5C3, 4'h0},
      '{32'h97000000, 1'h0, 32'h0083A5C3, 1'h1, 3'h7, 16'h0000, 4'h5},
      '{32'hF1000000, 1'h1, 32'h00000500, 1'h1, 3'h7, 16'h0000, 4'h5},
      '{32'h7F000000, 1'h1, 32'hF1000000, 1'h1, 3'h7, 16'h0000, 4'h0},
      '{32'h83000000, 1'h1, 32'h7F000000, 1'h1, 3'h3, 16'h0000, 4'h0},
      '{32'h02000100, 1'h1, 32'h83000000, 1'h1, 3'h2, 16'h0001, 4'h0}
   };

   dsc_link_if i_dsc_link_if ();
   dsc_link_if i_dsc_link_if_2 ();

   dsc_host i_dsc_host (.clk(clk), .rst(rst), .link(i_dsc_link_if), .start(start), .tx_word(tx_word),
      .tx_long(tx_long), .busy(busy), .done(done), .rx_word(rx_word));
   dsc_device i_dsc_device (.clk(clk), .rst(rst), .link(i_dsc_link_if), .crc_enable(1'h0),
      .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_data(cmd_data), .fault_len(fault_len),
      .fault_crc(fault_crc), .chan_code(chan_code), .chan_span(chan_span));
   dsc_device i_dsc_device_2 (.clk(clk), .rst(rst), .link(i_dsc_link_if_2), .crc_enable(1'h1),
      .cmd_valid(b_valid), .cmd_byte(), .cmd_data(), .fault_len(b_flen), .fault_crc(b_fcrc),
      .chan_code(b_code), .chan_span());
   dsc_link_sva i_dsc_link_sva (.clk(clk), .rst(rst), .frame_select_load(i_dsc_link_if.frame_select_load),
      .sck(i_dsc_link_if.sck), .sdi(i_dsc_link_if.sdi), .sdo_out(i_dsc_link_if.sdo_out),
      .sdo_oe(i_dsc_link_if.sdo_oe), .sdo(i_dsc_link_if.sdo));

   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   // ----------
   // Tasks
   // ----------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // One host frame, with a second start while busy that must be ignored
   task automatic send(input logic [31:0] w, input logic lg);
      start <= 1'h1;
      tx_word <= w;
      tx_long <= lg;
      @(posedge clk);
      start <= 1'h0;
      repeat (40) @(posedge clk);
      chk({31'h0, busy}, 32'h1);
      start <= 1'h1;
      @(posedge clk);
      start <= 1'h0;
      while (done !== 1'h1)
         @(posedge clk);
   endtask

   // Bench-made frame on the second link; sel high keeps the device deselected
   task automatic bad_frame(input int n, input logic [63:0] w, input logic sel);
      int k;
      i_dsc_link_if_2.frame_select_load <= sel;
      for (k = 0; k < n; k++) begin
         i_dsc_link_if_2.sdi <= w[63-k];
         repeat (4) @(posedge clk);
         i_dsc_link_if_2.sck <= 1'h1;
         repeat (4) @(posedge clk);
         i_dsc_link_if_2.sck <= 1'h0;
      end
      i_dsc_link_if_2.sdi <= ~i_dsc_link_if_2.sdi;
      repeat (5) @(posedge clk);
      i_dsc_link_if_2.frame_select_load <= 1'h1;
      repeat (15) @(posedge clk);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cmd_valid === 1'h1)
         n_valid++;
      if (b_valid === 1'h1)
         b_n++;
      if (cycles == 15000) begin
         n_errors++;
         results();
      end
   end

   // ----------
   // Sequence
   // ----------
   initial begin
      rst = 1'h1;
      start = 1'h0;
      tx_word = 32'h00000000;
      tx_long = 1'h0;
      i_dsc_link_if_2.frame_select_load = 1'h1;
      i_dsc_link_if_2.sck = 1'h0;
      i_dsc_link_if_2.sdi = 1'h0;
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      repeat (8) @(posedge clk);
      chk({31'h0, chan_code === '0}, 32'h1);
      chk({31'h0, chan_span === '0}, 32'h1);
      $display("reset test done");
      for (i = 0; i < 12; i++) begin
         nv = n_valid;
         send(rows[i].word, rows[i].long_f);
         chk(n_valid - nv, 32'h1);
         chk({24'h0, cmd_byte}, {24'h0, rows[i].word[31:24]});
         chk({16'h0, cmd_data}, {16'h0, rows[i].word[23:8]});
         chk({31'h0, fault_len}, 32'h0);
         chk({31'h0, fault_crc}, 32'h0);
         chk({31'h0, busy}, 32'h0);
         if (rows[i].chk_rx)
            chk(rx_word, rows[i].rx);
         chk({16'h0, chan_code[rows[i].ch]}, {16'h0, rows[i].code});
         chk({28'h0, chan_span[rows[i].ch]}, {28'h0, rows[i].span});
      end
      $display("row test done");
      bad_frame(31, 64'h0100010000000000, 1'h0);
      chk({31'h0, b_flen}, 32'h1);
      bad_frame(64, 64'h0100010000000000, 1'h0);
      chk({31'h0, b_flen}, 32'h1);
      bad_frame(32, 64'h0000000100000000, 1'h0);
      chk({30'h0, b_flen, b_fcrc}, 32'h1);
      chk(b_n, 32'h0);
      bad_frame(24, 64'h0012340000000000, 1'h0);
      chk({30'h0, b_flen, b_fcrc}, 32'h0);
      chk({16'h0, b_code[0]}, 32'h1234);
      bad_frame(32, 64'h7600001500000000, 1'h0);
      chk({31'h0, b_fcrc}, 32'h0);
      bad_frame(24, 64'h01FFFF0000000000, 1'h1);
      chk(b_n, 32'h2);
      chk({16'h0, b_code[1]}, 32'h0);
      $display("fault test done");
      start <= 1'h1;
      tx_word <= 32'h05FFFF00;
      tx_long <= 1'h1;
      @(posedge clk);
      start <= 1'h0;
      repeat (200) @(posedge clk);
      rst <= 1'h1;
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      repeat (8) @(posedge clk);
      chk({31'h0, chan_code === '0}, 32'h1);
      chk({31'h0, i_dsc_link_if.sdo_oe}, 32'h0);
      $display("midrun reset test done");
      results();
   end
endmodule

`default_nettype wire
